// [core/rsc_pkg.sv]
// rsc_pkg: shared constants and carrier types of the reset source controller.
// assumes one 25 MHz clock; internal reset sources arrive as active-high levels or pulses, the hard and soft reset pins active low.
`default_nettype none
package rsc_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned STRETCH_CYCLES = 512;
    localparam int unsigned RISE_CYCLES = 14;
    localparam int unsigned EXT_MIN_CYCLES = 32;
    localparam int unsigned CNT_W = 10;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic core;
        logic system;
        logic clock_module;
        logic ext_system;
        logic ext_soft;
        logic arbiter;
    } rsc_lines_t;

    typedef struct packed {
        logic power_up;
        logic watchdog;
        logic double_fault;
        logic clock_loss;
        logic reset_instr;
    } rsc_src_t;

    typedef enum logic [2:0] {
        RSC_CAUSE_NONE,
        RSC_CAUSE_HARD,
        RSC_CAUSE_SOFT,
        RSC_CAUSE_POWER,
        RSC_CAUSE_WATCHDOG,
        RSC_CAUSE_DFAULT,
        RSC_CAUSE_CLKLOSS,
        RSC_CAUSE_INSTR
    } rsc_cause_t;
endpackage : rsc_pkg
`default_nettype wire

// [core/rsc_reset_source_controller.sv]
// rsc_reset_source_controller: classifies reset causes, drives internal reset lines,
// stretches the shared open-drain hard and soft reset pins.
// assumes pin inputs are synchronous to clk after the two-stage synchroniser.
// one clock, no enables; every count is a parameter over the package defaults.
//
// Contract
// [RQ1] external system reset line pulls both hard and soft reset pins low
// [RQ2] external reset line pulls only the soft reset pin low
// [RQ3] clock module reset line resets the clock generation module
// [RQ4] internal system reset line resets memory, protection, serial, interrupt, parallel I/O
// [RQ5] internal core reset line resets all remaining internal circuits
// [RQ6] hard pin, power-up, double fault, clock loss async: all four; watchdog no clock
// [RQ7] external soft pin is synchronous: core line and external reset line only
// [RQ8] reset instruction: external reset line plus limited reset, no processor exception
// [RQ9] synchronous sources wait for the bus cycle end, even during locked cycles
// [RQ10] synchronous reset enables the bus monitor to end a stuck cycle
// [RQ11] only byte or word transfers survive a synchronous reset intact
// [RQ12] asynchronous sources reset immediately without waiting for the bus cycle
// [RQ13] any reset ends a bus cycle as if acknowledged or errored
// [RQ14] external drivers hold a reset pin low at least 32 clocks
// [RQ15] external soft pin detected: drive soft reset for 512 cycles
// [RQ16] external hard pin detected: drive hard and soft reset for 512 cycles
// [RQ17] release at the later of pin release or end of 512 cycles
// [RQ18] own soft reset pin drive always ends 512 cycles after assertion
// [RQ19] other sources hold reset at least 512 cycles and while asserted
// [RQ20] wait 14 cycles after release, then sample external reset before vector fetch
// [RQ21] during reset the external bus floats; untristatable outputs go inactive
// [RQ22] after both pins negate: controls inactive, data read, address driven, then fetch
// [RQ23] bus arbitration resets only on power-on reset
// [RQ24] external hard and soft pin inputs pass a two-stage synchroniser
`default_nettype none
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int unsigned STRETCH = STRETCH_CYCLES,
    parameter int unsigned RISE = RISE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hard_reset_pin_in,
    output logic hard_reset_pin_out,
    output logic hard_reset_pin_oe,
    input wire logic soft_reset_pin_in,
    output logic soft_reset_pin_out,
    output logic soft_reset_pin_oe,
    input wire rsc_src_t sources,
    input wire logic bus_cycle_active,
    input wire logic bus_cycle_end,
    input wire logic locked_cycle_strobe,
    output rsc_lines_t lines,
    output logic bus_monitor_force,
    output logic bus_cycle_abort,
    output logic bus_float,
    output logic bus_drive_idle,
    output logic vector_fetch_start,
    output rsc_cause_t cause
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic hard_meta;
    logic hard_sync;
    logic soft_meta;
    logic soft_sync;

    // only the second stage is read by anything downstream
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hard_meta <= 1'b1;
            hard_sync <= 1'b1;
            soft_meta <= 1'b1;
            soft_sync <= 1'b1;
        end else begin
            hard_meta <= hard_reset_pin_in; // RQ24
            hard_sync <= hard_meta;
            soft_meta <= soft_reset_pin_in;
            soft_sync <= soft_meta;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        RSC_RUN,
        RSC_SOFT_WAIT,
        RSC_STRETCH,
        RSC_HOLD,
        RSC_RISE,
        RSC_START
    } rsc_state_t;

    rsc_state_t state;
    rsc_state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    rsc_lines_t act;
    rsc_lines_t next_act;
    rsc_cause_t next_cause;
    logic pin_drive;
    logic next_pin_drive;

    // ----------------------------------------
    // request qualification
    // ----------------------------------------

    // own drive is excluded so we only react to other parties pulling the pins
    wire own_hard = pin_drive && act.ext_system;
    wire ext_hard = !hard_sync && !own_hard;
    wire ext_soft = !soft_sync && !pin_drive;

    wire async_src = ext_hard
                     || sources.power_up
                     || sources.watchdog
                     || sources.double_fault
                     || sources.clock_loss;
    wire sync_req = ext_soft || sources.reset_instr;

    // a locked sequence counts as busy until its own last cycle
    wire cycle_busy = bus_cycle_active || locked_cycle_strobe;
    // synchronous requests wait out the cycle, locked cycles included
    wire sync_ok = !cycle_busy || bus_cycle_end; // RQ9

    wire src_held = sources.power_up
                    || sources.watchdog
                    || sources.double_fault
                    || sources.clock_loss
                    || sources.reset_instr;
    wire pins_low = !hard_sync || !soft_sync;
    wire stretch_done = count == CNT_W'(STRETCH - 1);
    wire rise_done = count == CNT_W'(RISE - 1);
    wire in_reset = state != RSC_RUN
                    && state != RSC_SOFT_WAIT
                    && state != RSC_START;

    // ----------------------------------------
    // cause classification and line selection
    // ----------------------------------------
    // watchdog is the one catastrophic source that spares the clock module
    wire watchdog_only = sources.watchdog
                         && !ext_hard
                         && !sources.power_up
                         && !sources.double_fault
                         && !sources.clock_loss;

    rsc_lines_t async_lines;
    rsc_cause_t async_cause;
    always_comb begin
        async_lines = '0;
        async_lines.core = 1'b1; // RQ6
        async_lines.system = 1'b1;
        async_lines.ext_system = 1'b1;
        async_lines.clock_module = !watchdog_only;
        async_lines.arbiter = sources.power_up; // RQ23
        if (sources.power_up) begin
            async_cause = RSC_CAUSE_POWER;
        end else if (ext_hard) begin
            async_cause = RSC_CAUSE_HARD;
        end else if (sources.double_fault) begin
            async_cause = RSC_CAUSE_DFAULT;
        end else if (sources.clock_loss) begin
            async_cause = RSC_CAUSE_CLKLOSS;
        end else begin
            async_cause = RSC_CAUSE_WATCHDOG;
        end
    end

    rsc_lines_t soft_lines;
    always_comb begin
        soft_lines = '0;
        soft_lines.core = 1'b1; // RQ7 RQ8
        soft_lines.ext_soft = 1'b1;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        next_act = act;
        next_cause = cause;
        next_pin_drive = pin_drive;

        // own pin drive steps the count it shares with the stretch, whatever the state does
        if (pin_drive && stretch_done) begin
            next_pin_drive = 1'b0; // RQ18
        end else if (pin_drive) begin
            next_count = count + CNT_W'(1);
        end

        case (state)
            RSC_RUN, RSC_SOFT_WAIT, RSC_START: begin
                next_state = (state == RSC_START) ? RSC_RUN : state;
                if (async_src) begin
                    next_state = RSC_STRETCH; // RQ12
                    next_act = async_lines;
                    next_cause = async_cause;
                    next_count = '0;
                    next_pin_drive = 1'b1; // RQ16
                end else if (sync_req) begin
                    next_state = RSC_SOFT_WAIT;
                    if (sync_ok) begin
                        next_state = RSC_STRETCH;
                        next_act = soft_lines;
                        next_cause = ext_soft ? RSC_CAUSE_SOFT : RSC_CAUSE_INSTR;
                        next_count = '0;
                        next_pin_drive = 1'b1; // RQ15
                    end
                end
            end

            RSC_STRETCH: begin
                if (async_src && !act.system) begin
                    // escalate soft to hard reset
                    next_act = async_lines;
                    next_cause = async_cause;
                end
                if (stretch_done) begin
                    next_state = RSC_HOLD;
                end
            end

            RSC_HOLD: begin
                // later of pin release and stretch end, sources must also drop
                if (!pins_low && !src_held) begin // RQ17 RQ19
                    next_state = RSC_RISE;
                    next_act = '0;
                    next_count = '0;
                end
            end

            RSC_RISE: begin
                next_count = count + CNT_W'(1);
                if (async_src) begin
                    // a catastrophic source during rise starts over at once
                    next_state = RSC_STRETCH; // RQ12
                    next_act = async_lines;
                    next_cause = async_cause;
                    next_count = '0;
                    next_pin_drive = 1'b1;
                end else if (rise_done) begin
                    if (pins_low) begin // RQ20
                        next_state = RSC_HOLD;
                        next_act = soft_lines;
                    end else begin
                        next_state = RSC_START;
                    end
                end
            end

            default: begin
                next_state = RSC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // reset itself acts as a power-up source
            state <= RSC_STRETCH;
            count <= '0;
            act <= '{
                core: 1'b1,
                system: 1'b1,
                clock_module: 1'b1,
                ext_system: 1'b1,
                ext_soft: 1'b0,
                arbiter: 1'b1
            };
            cause <= RSC_CAUSE_POWER;
            pin_drive <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            act <= next_act;
            cause <= next_cause;
            pin_drive <= next_pin_drive;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign lines = act; // RQ3 RQ4 RQ5

    // open drain: only ever drive low
    assign hard_reset_pin_out = 1'b0;
    assign soft_reset_pin_out = 1'b0;
    assign hard_reset_pin_oe = pin_drive && act.ext_system; // RQ1
    assign soft_reset_pin_oe = pin_drive && (act.ext_system || act.ext_soft); // RQ2

    // ----------------------------------------
    // bus side
    // ----------------------------------------
    // soft wait lets the monitor end a hung cycle; byte or word only survive
    assign bus_monitor_force = state == RSC_SOFT_WAIT; // RQ10 RQ11
    assign bus_cycle_abort = in_reset && bus_cycle_active; // RQ13
    assign bus_float = in_reset; // RQ21
    assign bus_drive_idle = in_reset || state == RSC_START; // RQ22
    assign vector_fetch_start = state == RSC_START; // RQ22

endmodule : rsc_reset_source_controller
`default_nettype wire

// [test/rsc_pin_partner.sv]
// rsc_pin_partner: outside device sharing the open-drain hard and soft reset wires.
// assumes pull-ups on both wires; the bench asks it to pull.
`default_nettype none
module rsc_pin_partner
    import rsc_pkg::*;
(
    input wire logic clk,
    input wire logic pull_hard,
    input wire logic pull_soft,
    input wire logic hard_out,
    input wire logic hard_oe,
    input wire logic soft_out,
    input wire logic soft_oe,
    output logic hard_level,
    output logic soft_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] hold_h = '0;
    logic [5:0] hold_s = '0;
    // a short request is stretched so the device always sees a legal pulse
    always @(posedge clk) begin
        hold_h <= pull_hard ? 6'(EXT_MIN_CYCLES) : hold_h - 6'(hold_h != 0);
        hold_s <= pull_soft ? 6'(EXT_MIN_CYCLES) : hold_s - 6'(hold_s != 0);
    end
    // pull-up wins when nobody pulls
    assign hard_level = !(hard_oe && !hard_out) && !pull_hard && hold_h == 6'h00;
    assign soft_level = !(soft_oe && !soft_out) && !pull_soft && hold_s == 6'h00;
endmodule : rsc_pin_partner
`default_nettype wire

// [test/rsc_chk_assertions.sv]
// rsc_chk: port checks of the reset source controller.
// assumes binding to the controller with its stretch and rise counts.
`default_nettype none
module rsc_chk
    import rsc_pkg::*;
#(
    parameter int unsigned STRETCH = STRETCH_CYCLES,
    parameter int unsigned RISE = RISE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hard_reset_pin_oe,
    input wire logic soft_reset_pin_oe,
    input wire logic bus_cycle_active,
    input wire logic bus_cycle_end,
    input wire rsc_lines_t lines,
    input wire logic bus_cycle_abort,
    input wire logic bus_float,
    input wire logic vector_fetch_start
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RLO = RISE;
    localparam int RHI = RISE + 2;
    logic [CNT_W:0] oe_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // counter stands in for a repetition far beyond what tools unroll
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_len <= '0;
        end else begin
            oe_len <= soft_reset_pin_oe ? oe_len + 1'b1 : '0;
        end
    end
    property p_hard_both; hard_reset_pin_oe |-> soft_reset_pin_oe; endproperty
    a_hard_both: assert property (p_hard_both) else $error("hard pin alone");
    property p_oe_len; soft_reset_pin_oe |-> oe_len < STRETCH; endproperty
    a_oe_len: assert property (p_oe_len) else $error("soft drive too long");
    property p_clk_line; lines.clock_module |-> lines.core && lines.system && lines.ext_system;
    endproperty
    a_clk_line: assert property (p_clk_line) else $error("clock reset alone");
    property p_soft_only; lines.ext_soft && !lines.ext_system |-> !lines.system && !lines.clock_module;
    endproperty
    a_soft_only: assert property (p_soft_only) else $error("soft reset too wide");
    property p_sync_wait; $rose(lines.ext_soft) && !lines.ext_system |->
        $past(!bus_cycle_active || bus_cycle_end); endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("soft mid cycle");
    property p_rise; $fell(lines.core) |-> ##[RLO:RHI] vector_fetch_start; endproperty
    a_rise: assert property (p_rise) else $error("fetch not after rise");
    property p_fetch_clean; vector_fetch_start |->
        !bus_float && !hard_reset_pin_oe && !soft_reset_pin_oe && !lines.core; endproperty
    a_fetch_clean: assert property (p_fetch_clean) else $error("fetch in reset");
    property p_abort; bus_float && bus_cycle_active |-> bus_cycle_abort; endproperty
    a_abort: assert property (p_abort) else $error("cycle not ended");
endmodule : rsc_chk
bind rsc_reset_source_controller rsc_chk #(.STRETCH(STRETCH), .RISE(RISE)) rsc_chk_inst (
    .clk(clk), .nrst(nrst), .hard_reset_pin_oe(hard_reset_pin_oe),
    .soft_reset_pin_oe(soft_reset_pin_oe), .bus_cycle_active(bus_cycle_active),
    .bus_cycle_end(bus_cycle_end), .lines(lines), .bus_cycle_abort(bus_cycle_abort),
    .bus_float(bus_float), .vector_fetch_start(vector_fetch_start));
`default_nettype wire

// [test/tb.sv]
// tb: self-checking bench of the reset source controller with a pin partner.
// assumes stretch shortened to 16 and rise to 4.
`default_nettype none
module tb;
    import rsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, pull_hard = 1'b0, pull_soft = 1'b0;
    logic act = 1'b0, fin = 1'b0, lock = 1'b0;
    logic hard_out, hard_oe, soft_out, soft_oe, hard_level, soft_level;
    logic force_mon, abort, float, idle, fetch;
    rsc_src_t sources = '0;
    rsc_lines_t lines;
    rsc_cause_t cause;
    int err_count = 0, n_tests = 0, cycles = 0;
    rsc_cause_t cz [5] = '{RSC_CAUSE_POWER, RSC_CAUSE_WATCHDOG, RSC_CAUSE_DFAULT,
        RSC_CAUSE_CLKLOSS, RSC_CAUSE_INSTR};
    rsc_reset_source_controller #(.STRETCH(16), .RISE(4)) rsc_reset_source_controller_inst (
        .clk(clk), .nrst(nrst), .hard_reset_pin_in(hard_level), .hard_reset_pin_out(hard_out),
        .hard_reset_pin_oe(hard_oe), .soft_reset_pin_in(soft_level), .soft_reset_pin_out(soft_out),
        .soft_reset_pin_oe(soft_oe), .sources(sources), .bus_cycle_active(act),
        .bus_cycle_end(fin), .locked_cycle_strobe(lock), .lines(lines),
        .bus_monitor_force(force_mon), .bus_cycle_abort(abort), .bus_float(float),
        .bus_drive_idle(idle), .vector_fetch_start(fetch), .cause(cause));
    rsc_pin_partner rsc_pin_partner_inst (.clk(clk), .pull_hard(pull_hard),
        .pull_soft(pull_soft), .hard_out(hard_out), .hard_oe(hard_oe), .soft_out(soft_out),
        .soft_oe(soft_oe), .hard_level(hard_level), .soft_level(soft_level));
    initial begin
        forever #20 clk = ~clk;
    end
    // -------------------------------------------
    // shared tasks
    // -------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_fetch;
        int i;
        i = 0;
        while (fetch !== 1'b1 && i < 200) begin
            cyc(1);
            i++;
        end
        chk("fetch", 8'h01, {7'h00, fetch});
    endtask : wait_fetch
    task automatic results;
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    task automatic t_power;
        chk("power lines", 8'h1E, {3'h0, lines[5:1]});
        chk("power oe", 8'h03, {6'h00, hard_oe, soft_oe});
        chk("power arbiter", 8'h01, {7'h00, lines.arbiter});
        chk("pin out", 8'h00, {6'h00, hard_out, soft_out});
        wait_fetch();
    endtask : t_power
    task automatic t_soft;
        @(posedge clk) begin
            act <= 1'b1;
            lock <= 1'b1;
            pull_soft <= 1'b1;
        end
        @(posedge clk) pull_soft <= 1'b0;
        cyc(6);
        chk("core early", 8'h00, {7'h00, lines.core});
        chk("monitor", 8'h01, {7'h00, force_mon});
        @(posedge clk) fin <= 1'b1;
        @(posedge clk) begin
            fin <= 1'b0;
            act <= 1'b0;
            lock <= 1'b0;
        end
        cyc(2);
        chk("soft lines", 8'h11, {3'h0, lines[5:1]});
        chk("soft oe", 8'h01, {6'h00, hard_oe, soft_oe});
        chk("soft cause", 8'(RSC_CAUSE_SOFT), 8'(cause));
        cyc(18);
        chk("soft late", 8'h01, {6'h00, soft_oe, lines.core});
        wait_fetch();
    endtask : t_soft
    task automatic t_hard;
        @(posedge clk) pull_hard <= 1'b1;
        @(posedge clk) pull_hard <= 1'b0;
        cyc(5);
        chk("hard oe", 8'h03, {6'h00, hard_oe, soft_oe});
        chk("hard lines", 8'h1E, {3'h0, lines[5:1]});
        chk("hard cause", 8'(RSC_CAUSE_HARD), 8'(cause));
        chk("hard arbiter", 8'h00, {7'h00, lines.arbiter});
        cyc(20);
        chk("hard late", 8'h01, {5'h00, hard_oe, soft_oe, lines.ext_system});
        wait_fetch();
    endtask : t_hard
    task automatic t_src(input int k);
        logic [4:0] exp;
        exp = (k == 3) ? 5'h1A : (k == 0) ? 5'h11 : 5'h1E;
        @(posedge clk) begin
            sources <= 5'(1 << k);
            act <= (k != 0);
        end
        cyc(2);
        chk("src lines", {3'h0, exp}, {3'h0, lines[5:1]});
        chk("src abort", {7'h00, k != 0}, {7'h00, abort});
        chk("src float", 8'h03, {6'h00, float, idle});
        chk("src cause", 8'(cz[4 - k]), 8'(cause));
        cyc(20);
        chk("src held", 8'h01, {7'h00, lines.core});
        @(posedge clk) begin
            sources <= '0;
            act <= 1'b0;
        end
        wait_fetch();
    endtask : t_src
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        t_power();
        t_soft();
        t_hard();
        for (int k = 4; k >= 0; k--) begin
            t_src(k);
        end
        results();
    end
    // run is near 270 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end
endmodule : tb
`default_nettype wire
